// file: rtl/tec_timer3.sv
`timescale 1ns/100ps
`include "tec_params.svh"
module tec_timer3
  import tec_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [4:0]   s_axi_awaddr,
  input  wire logic [2:0]   s_axi_awprot,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [4:0]   s_axi_araddr,
  input  wire logic [2:0]   s_axi_arprot,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         timer_input_pin,
  output logic              timer_match_interrupt
);
  import tec_pkg::*;

  function automatic logic div_tick(input logic [14:0] p,
                                    input logic [3:0]  n);
    logic [14:0] m;
    m = (15'h0001 << n) - 15'h0001;
    return (p & m) == m;
  endfunction

  tec_byte_type timer_control_reg, compare_capture_a_reg, capture_b_reg;
  tec_byte_type port_mux_control_reg, remote_rx_control_reg;
  tec_byte_type count, next_count;
  logic [14:0]  prescale;
  logic         pin_s1, pin_s2, pin_d;
  logic         filt, filt_d, noise_detect_flag, noise_overflow_flag;
  logic [4:0]   filt_cnt;
  wire          aw_held = ~s_axi_awready; // ready flops double as held
  wire          w_held  = ~s_axi_wready;
  logic [4:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;

  // control decode
  wire [2:0] source_clock_select = timer_control_reg[`TEC_CTRL_CLK_LSB+:3];
  wire run_control             = timer_control_reg[`TEC_CTRL_RUN];
  wire auto_capture_enable     = timer_control_reg[`TEC_CTRL_AUTO_CAPTURE_ENABLE];
  wire input_invert_select     = port_mux_control_reg[`TEC_PMUX_INV];
  wire prescaler_divide_select = port_mux_control_reg[`TEC_PMUX_DIV];
  wire [4:0] noise_reject_count = remote_rx_control_reg[4:0];
  wire rx_sck = remote_rx_control_reg[`TEC_RXC_SCK];
  wire rx_pol = remote_rx_control_reg[`TEC_RXC_POL];
  wire rx_en  = remote_rx_control_reg[`TEC_RXC_EN];
  tec_mode_type mode;
  assign mode = timer_control_reg[`TEC_CTRL_CAPMODE] ? tec_mode_capture :
                (source_clock_select == `TEC_CLK_EXT) ? tec_mode_event :
                tec_mode_timer;

  // divided source clocks
  wire [3:0] div_n = `TEC_DIV_BASE - {1'b0, source_clock_select}
                     + {3'h0, prescaler_divide_select};
  wire src_tick = div_tick(prescale, div_n);
  wire rx_tick  = rx_sck ? src_tick :
                  div_tick(prescale, `TEC_RX_DIV_BASE
                                     + {3'h0, prescaler_divide_select});

  // pin edges after synchroniser
  wire pin_rise = pin_s2 & ~pin_d;
  wire pin_fall = ~pin_s2 & pin_d;
  wire ev_edge  = input_invert_select ? pin_fall : pin_rise;

  // noise reject: accept a level after count minus one filter ticks, a count below 2 taken as 2
  wire [4:0] nc_eff  = (noise_reject_count < `TEC_NC_MIN) ? `TEC_NC_MIN
                                                          : noise_reject_count;
  wire [4:0] nc_done = nc_eff - 5'h01;
  wire filt_diff   = pin_s2 != filt;
  wire filt_accept = filt_diff & (~rx_en | (rx_tick & (filt_cnt + 5'h01
                                                    >= nc_done)));
  wire glitch      = rx_en & ~filt_diff & (filt_cnt != 5'h00);
  wire cap_in      = filt ^ rx_pol;
  wire cap_in_d    = filt_d ^ rx_pol;
  wire cap_rise    = cap_in & ~cap_in_d;
  wire cap_fall    = ~cap_in & cap_in_d;
  wire a_edge = input_invert_select ? cap_fall : cap_rise;
  wire b_edge = input_invert_select ? cap_rise : cap_fall;

  // counter events
  wire hit       = count == compare_capture_a_reg;
  wire tmr_fire  = run_control & (mode == tec_mode_timer) & src_tick & hit;
  wire ev_fire   = run_control & (mode == tec_mode_event) & pin_fall
                   & hit;
  wire cap_fire  = run_control & (mode == tec_mode_capture) & a_edge;
  wire cap_b     = run_control & (mode == tec_mode_capture) & b_edge;
  wire fire      = tmr_fire | ev_fire | cap_fire;
  wire inc = run_control & (((mode != tec_mode_event) & src_tick)
                            | ((mode == tec_mode_event) & ev_edge));

  always_comb begin
    next_count = count;
    if (!run_control) begin
      next_count = 8'h00;
    end else if (fire) begin
      next_count = 8'h00;
    end else if (inc) begin
      next_count = count + 8'h01;
    end
  end

  // bus decode
  wire aw_go   = aw_held & w_held & ~s_axi_bvalid;
  wire wr_en   = aw_go & w_strb[0];
  wire [3:0] wa = {aw_addr[3:2], 2'h0};
  wire wr_hi   = aw_addr[4];
  wire wr_ctrl = wr_en & ~wr_hi & (wa == `TEC_OFS_CTRL);
  wire wr_cmpa = wr_en & ~wr_hi & (wa == `TEC_OFS_CMPA);
  wire wr_pmux = wr_en & ~wr_hi & (wa == `TEC_OFS_PMUX);
  wire wr_rxc  = wr_en & wr_hi & (wa == `TEC_OFS_RXCTL);
  wire wr_map  = ~wr_hi ? (wa != `TEC_OFS_CAPB)
                        : (wa == `TEC_OFS_RXCTL);
  wire rd_go   = s_axi_arvalid & s_axi_arready;
  wire [3:0] ra = {s_axi_araddr[3:2], 2'h0};
  wire rd_hi   = s_axi_araddr[4];
  wire rd_sts  = rd_go & rd_hi & (ra == `TEC_OFS_RXSTS);
  wire rd_map  = ~rd_hi | (ra == `TEC_OFS_RXCTL) | (ra == `TEC_OFS_RXSTS);
  wire [7:0] rx_status = {noise_detect_flag, rx_pol, rx_sck,
                          noise_overflow_flag, filt, 3'h0};
  wire [7:0] rd_byte =
    ~rd_hi ? ((ra == `TEC_OFS_CTRL) ? timer_control_reg :
              (ra == `TEC_OFS_CMPA) ? compare_capture_a_reg :
              (ra == `TEC_OFS_CAPB) ? capture_b_reg : port_mux_control_reg)
           : ((ra == `TEC_OFS_RXCTL) ? remote_rx_control_reg :
              (ra == `TEC_OFS_RXSTS) ? rx_status : 8'h00);

  // synchroniser and edge history
  always_ff @(posedge aclk) begin
    pin_s1 <= timer_input_pin;
    pin_s2 <= pin_s1;
    pin_d  <= pin_s2;
    filt_d <= filt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 15'h0000;
      count    <= 8'h00;
      timer_match_interrupt <= 1'b0;
    end else begin
      prescale <= prescale + 15'h0001;
      count    <= next_count;
      timer_match_interrupt <= fire;
    end
  end

  // noise reject stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt     <= 1'b0;
      filt_cnt <= 5'h00;
    end else if (filt_accept) begin
      filt     <= pin_s2;
      filt_cnt <= 5'h00;
    end else if (!filt_diff) begin
      filt_cnt <= 5'h00;
    end else if (rx_tick) begin
      filt_cnt <= filt_cnt + 5'h01;
    end
  end

  // set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noise_detect_flag   <= 1'b0;
      noise_overflow_flag <= 1'b0;
    end else begin
      noise_detect_flag   <= glitch
                             | (noise_detect_flag & ~rd_sts);
      noise_overflow_flag <= (glitch & noise_detect_flag)
                             | (noise_overflow_flag & ~rd_sts);
    end
  end

  // data registers; B untouched until its own edge in capture mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_capture_a_reg <= `TEC_RST_CMPA;
      capture_b_reg         <= `TEC_RST_CAPB;
    end else begin
      if (cap_fire) begin
        compare_capture_a_reg <= count;
      end else if (wr_cmpa) begin
        compare_capture_a_reg <= w_data[7:0];
      end
      if (cap_b) begin
        capture_b_reg <= count;
      end else if (auto_capture_enable && mode != tec_mode_capture) begin
        capture_b_reg <= count; // unsynchronised copy
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_reg     <= `TEC_RST_CTRL;
      port_mux_control_reg  <= `TEC_RST_PMUX;
      remote_rx_control_reg <= `TEC_RST_RXCTL;
    end else begin
      if (wr_ctrl) timer_control_reg <= w_data[7:0];
      if (wr_pmux) port_mux_control_reg <= w_data[7:0];
      if (wr_rxc) remote_rx_control_reg <= w_data[7:0];
    end
  end

  // axi write path, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr <= 5'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TEC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end else if (aw_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (aw_go) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TEC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_map ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_timer_match: assert property (@(posedge aclk)
    disable iff (!aresetn)
    tmr_fire |=> timer_match_interrupt && count == 8'h00)
    else $error("timer match did not interrupt and clear");
  a_timer_step: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (run_control && mode == tec_mode_timer && src_tick && !hit && !wr_ctrl)
    |=> count == $past(count) + 8'h01)
    else $error("timer did not step on source tick");
  a_auto_copy: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (auto_capture_enable && mode != tec_mode_capture)
    |=> capture_b_reg == $past(count))
    else $error("auto capture copy missing");
  a_event_step: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (run_control && mode == tec_mode_event && ev_edge && !ev_fire
     && !wr_ctrl) |=> count == $past(count) + 8'h01)
    else $error("event edge not counted");
  a_event_match: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ev_fire |=> timer_match_interrupt && count == 8'h00)
    else $error("event match lost");
  a_no_low_match: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (mode == tec_mode_event && !pin_fall && !wr_ctrl)
    |=> !timer_match_interrupt)
    else $error("interrupt without falling edge");
  a_capture_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    cap_fire |=> compare_capture_a_reg == $past(count)
                 && count == 8'h00 && timer_match_interrupt)
    else $error("register A capture wrong");
  a_capture_b: assert property (@(posedge aclk)
    disable iff (!aresetn)
    cap_b |=> capture_b_reg == $past(count) && !timer_match_interrupt)
    else $error("register B capture wrong");
  a_stop_clear: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !run_control |=> count == 8'h00)
    else $error("stopped counter not cleared");
  a_read_clear: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (rd_sts && !glitch) |=> !noise_detect_flag && !noise_overflow_flag)
    else $error("status read did not clear flags");
endmodule

// file: rtl/tec_params.svh
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH
`define TEC_OFS_CTRL      4'h0
`define TEC_OFS_CMPA      4'h4
`define TEC_OFS_CAPB      4'h8
`define TEC_OFS_PMUX      4'hC
`define TEC_ADDR_HI       3'h1
`define TEC_OFS_RXCTL     4'h4
`define TEC_OFS_RXSTS     4'h8
`define TEC_CTRL_CLK_LSB  1
`define TEC_CTRL_RUN      4
`define TEC_CTRL_CAPMODE  5
`define TEC_CTRL_AUTO_CAPTURE_ENABLE     6
`define TEC_PMUX_INV      0
`define TEC_PMUX_DIV      1
`define TEC_RXC_SCK       5
`define TEC_RXC_POL       6
`define TEC_RXC_EN        7
`define TEC_RST_CTRL      8'h00
`define TEC_RST_CMPA      8'h00
`define TEC_RST_CAPB      8'hFF
`define TEC_RST_PMUX      8'h00
`define TEC_RST_RXCTL     8'h1F
`define TEC_CLK_EXT       3'h7
`define TEC_DIV_BASE      4'hD
`define TEC_RX_DIV_BASE   4'h8
`define TEC_NC_MIN        5'h02
`define TEC_RESP_OKAY     2'h0
`define TEC_RESP_SLVERR   2'h2
`endif

// file: rtl/tec_pkg.sv
package tec_pkg;
  typedef enum logic [1:0] {
    tec_mode_timer,
    tec_mode_event,
    tec_mode_capture
  } tec_mode_type;
  typedef logic [7:0] tec_byte_type;
endpackage

// file: verif/tec_pulse_src.sv
`timescale 1ns/100ps
module tec_pulse_src (
  input  wire logic aclk,
  output logic      pin
);
  initial pin = 1'b0;
  // each level held two cycles or more, else it is lost
  task automatic lvl(input logic v, input int n);
    @(posedge aclk);
    pin <= v;
    repeat (n < 2 ? 2 : n) @(posedge aclk);
  endtask
endmodule

// file: verif/tec_timer3_bench.sv
`timescale 1ns/100ps
module tec_timer3_bench;
  import tec_pkg::*;
  typedef struct {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0]  rsp;
  } tec_note_type;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic         bready, arvalid, arready, rvalid, rready, pin, irq, div;
  logic [4:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, blo, bhi;
  logic [1:0]   bresp, rresp;
  logic [2:0]   code;
  int           fail_count, n_tests, irq_cnt, cyc, t0, t1, lo, w;
  tec_note_type q[$];
  tec_note_type nt;
  tec_timer3 i_tec_timer3 (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_input_pin(pin),
    .timer_match_interrupt(irq));
  tec_pulse_src i_tec_pulse_src (.aclk(aclk), .pin(pin));
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  // a response pops the oldest note; read data must fall inside its range
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      nt = q.pop_front();
      n_tests++;
      if ((bvalid ? bresp : rresp) !== nt.rsp ||
          (rvalid && (rdata >= nt.lo && rdata <= nt.hi) !== 1'b1)) begin
        fail_count++;
        $display("wrong value at %0t: got %h/%h expected %h..%h/%h",
                 $time, rdata, bvalid ? bresp : rresp, nt.lo, nt.hi, nt.rsp);
      end
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic [1:0] r = 2'h0);
    @(posedge aclk);
    q.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] l,
                    input logic [31:0] h, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    q.push_back('{l, h, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wirq(output int t);
    do @(posedge aclk); while (irq !== 1'b1);
    t = cyc;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // long codes 000 and 001 left out to keep the run short
  initial begin
    repeat (50000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata, cyc, irq_cnt, fail_count, n_tests} = '0;
    lo = $urandom(85);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h00, 32'h0, 32'h0);
    rd(5'h08, 32'hFF, 32'hFF);
    rd(5'h14, 32'h1F, 32'h1F);
    rd(5'h10, 32'h0, 32'h0, 2'h2);
    wr(5'h08, 8'h00, 2'h2);
    rd(5'h08, 32'hFF, 32'hFF);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      code = (i < 5) ? 3'(2 + i) : 3'h6;
      div = (i == 5);
      wr(5'h00, 8'h00);
      wr(5'h0C, {6'h0, div, 1'b0});
      wr(5'h04, 8'h01);
      wr(5'h00, {3'h0, 1'b1, code, 1'b0});
      wirq(t0);
      wirq(t1);
      chk(t1 - t0, 2 << (13 - code + div));
    end
    $display("test timer done");
    for (int inv = 1; inv >= 0; inv--) begin
      wr(5'h00, 8'h00);
      wr(5'h04, 8'h02);
      wr(5'h0C, 8'(inv));
      wr(5'h00, 8'h5E);
      w = 2 + $urandom % 6;
      i_tec_pulse_src.lvl(1'b1, w);
      i_tec_pulse_src.lvl(1'b0, 8);
      rd(5'h08, 32'h1, 32'h1);
    end
    lo = irq_cnt;
    i_tec_pulse_src.lvl(1'b1, 8);
    chk(irq_cnt, lo);
    i_tec_pulse_src.lvl(1'b0, 8);
    chk(irq_cnt, lo + 1);
    $display("test event done");
    aresetn <= 1'b0; // second reset, so B is back at FF
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    blo = 32'hFF;
    bhi = 32'hFF;
    for (int inv = 0; inv < 2; inv++) begin
      wr(5'h00, 8'h00);
      wr(5'h0C, 8'(inv));
      i_tec_pulse_src.lvl(1'(inv), 8);
      wr(5'h00, 8'h3C);
      lo = irq_cnt;
      i_tec_pulse_src.lvl(!inv, 1280);
      chk(irq_cnt, lo + 1);
      rd(5'h08, blo, bhi);
      i_tec_pulse_src.lvl(1'(inv), 640);
      rd(5'h08, 32'd9, 32'd11);
      i_tec_pulse_src.lvl(!inv, 8);
      rd(5'h04, 32'd14, 32'd16);
      chk(irq_cnt, lo + 2);
      blo = 32'd9;
      bhi = 32'd11;
    end
    $display("test capture done");
    wr(5'h00, 8'h00);
    wr(5'h0C, 8'h00);
    wr(5'h14, 8'h9F);
    wr(5'h00, 8'h3C);
    rd(5'h18, 32'h0, 32'h0);
    lo = irq_cnt;
    i_tec_pulse_src.lvl(1'b1, 300);
    i_tec_pulse_src.lvl(1'b0, 20);
    rd(5'h18, 32'h80, 32'h80);
    rd(5'h18, 32'h0, 32'h0);
    i_tec_pulse_src.lvl(1'b1, 300);
    i_tec_pulse_src.lvl(1'b0, 20);
    i_tec_pulse_src.lvl(1'b1, 500);
    i_tec_pulse_src.lvl(1'b0, 20);
    rd(5'h18, 32'h90, 32'h90);
    chk(irq_cnt, lo);
    wr(5'h00, 8'h00);
    wr(5'h14, 8'h82);
    wr(5'h00, 8'h3C);
    i_tec_pulse_src.lvl(1'b1, 800);
    rd(5'h18, 32'h08, 32'h08);
    chk(irq_cnt, lo + 1);
    $display("test noise done");
    end_sim();
  end
endmodule
